// ### gysb_pkg.sv
// shared constants of the gyro sample buffer: register indices, field layout,
// mode codes and reset values
// assumes: registers are one byte wide, one per aligned apb word (byte address = 4 * index)
`default_nettype none

package gysb_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int DEPTH_DEF = 32;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam int AUTO_INC_BIT = 7;

  // ------------------------------------------------------------------
  // register indices (sub-addresses)
  // ------------------------------------------------------------------
  localparam logic [6:0] IDX_INT_CTRL = 7'h22;
  localparam logic [6:0] IDX_OUT_XL = 7'h28;
  localparam logic [6:0] IDX_OUT_XH = 7'h29;
  localparam logic [6:0] IDX_OUT_YL = 7'h2a;
  localparam logic [6:0] IDX_OUT_YH = 7'h2b;
  localparam logic [6:0] IDX_OUT_ZL = 7'h2c;
  localparam logic [6:0] IDX_OUT_ZH = 7'h2d;
  localparam logic [6:0] IDX_BUF_CTRL = 7'h2e;
  localparam logic [6:0] IDX_BUF_SRC = 7'h2f;
  localparam logic [6:0] IDX_TRIG_CFG = 7'h30;

  // ------------------------------------------------------------------
  // buffer_control fields
  // ------------------------------------------------------------------
  localparam int MODE_LSB = 5;
  localparam int MODE_W = 3;
  localparam int WTM_LSB = 0;
  localparam int WTM_W = 5;
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_FIFO = 3'h1;
  localparam logic [2:0] MODE_STREAM = 3'h2;
  localparam logic [2:0] MODE_B2S = 3'h3;
  localparam logic [2:0] MODE_S2F = 3'h4;

  // ------------------------------------------------------------------
  // interrupt_pin_control, buffer_source_flags, trigger_event_config bits
  // ------------------------------------------------------------------
  localparam int IEN_EMPTY_BIT = 0;
  localparam int IEN_FULL_BIT = 1;
  localparam int IEN_WTM_BIT = 2;
  localparam int SRC_EMPTY_BIT = 5;
  localparam int SRC_FULL_BIT = 6;
  localparam int SRC_WTM_BIT = 7;
  localparam int TRIG_EN_BIT = 0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_BUF_CTRL = 8'h00;
  localparam logic [7:0] RST_TRIG_CFG = 8'h00;

endpackage : gysb_pkg

`default_nettype wire

// ### gysb_samp_if.sv
// carrier between the link-side sample catcher and the buffer core
// assumes: valid and trig are in the pclk domain once they reach the core; x, y, z are link_clk hold registers
`default_nettype none

interface gysb_samp_if;
  logic valid;
  logic trig;
  logic [gysb_pkg::DATA_W-1:0] x;
  logic [gysb_pkg::DATA_W-1:0] y;
  logic [gysb_pkg::DATA_W-1:0] z;

  modport link (output valid, output trig, output x, output y, output z);
  modport core (input valid, input trig, input x, input y, input z);
endinterface : gysb_samp_if

`default_nettype wire

// ### gysb_link_sync.sv
// link-side capture of sample triplets and trigger events, crossed into pclk
// assumes: samp_strobe and trig_pulse are one-cycle pulses on link_clk
`default_nettype none

module gysb_link_sync
  import gysb_pkg::*;
(
  // clocks and reset
  input wire logic pclk,
  input wire logic link_clk,
  input wire logic presetn,
  // link side
  input wire logic samp_strobe,
  input wire logic [DATA_W-1:0] samp_x,
  input wire logic [DATA_W-1:0] samp_y,
  input wire logic [DATA_W-1:0] samp_z,
  input wire logic trig_pulse,
  // core side
  gysb_samp_if.link sio
);

  // ------------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------------
  logic req_q;
  logic trig_tgl_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic sio_ack_q;
  logic [DATA_W-1:0] hold_x_q;
  logic [DATA_W-1:0] hold_y_q;
  logic [DATA_W-1:0] hold_z_q;
  wire logic busy = req_q ^ ack_s2_q;
  // a sample arriving while the previous one is still crossing is lost: no buffering
  wire logic take = samp_strobe & ~busy;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      trig_tgl_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      hold_x_q <= '0;
      hold_y_q <= '0;
      hold_z_q <= '0;
    end else begin
      ack_s1_q <= sio_ack_q;
      ack_s2_q <= ack_s1_q;
      trig_tgl_q <= trig_tgl_q ^ trig_pulse;
      if (take) begin
        req_q <= ~req_q;
        hold_x_q <= samp_x;
        hold_y_q <= samp_y;
        hold_z_q <= samp_z;
      end
    end
  end

  // ------------------------------------------------------------------
  // pclk domain
  // ------------------------------------------------------------------
  logic req_s1_q;
  logic req_s2_q;
  logic trg_s1_q;
  logic trg_s2_q;
  logic trg_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      sio_ack_q <= 1'b0;
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      sio_ack_q <= req_s2_q;
      trg_s1_q <= trig_tgl_q;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  // hold registers stay still until the ack returns, so the words need no synchroniser
  assign sio.valid = req_s2_q ^ sio_ack_q;
  assign sio.trig = trg_s2_q ^ trg_s3_q;
  assign sio.x = hold_x_q;
  assign sio.y = hold_y_q;
  assign sio.z = hold_z_q;

endmodule : gysb_link_sync

`default_nettype wire

// ### gysb_buffer.sv
// gyro sample buffer: three-channel sample store with apb register access
// assumes: apb3 master on pclk; samples and trigger pulses arrive on link_clk
// Operation
// - 32 slots of 16 bits per channel
// - five modes chosen in buffer_control
// - watermark, empty, full each enable interrupt pin
// - source register reports current buffer flags
// - 5-bit watermark threshold in buffer_control
// - bypass keeps buffer empty
// - bypass overwrites first slot each sample
// - fifo mode stores until full, then ignores
// - watermark interrupt when level reaches threshold
// - stream mode drops oldest when full
// - bypass-to-stream switches on trigger event
// - stream-to-fifo switches on trigger event
// - buffered modes read stored samples
// - retrieval loads oldest triplet into outputs
// - burst reading wraps from 2Dh to 28h
// - sub-address: 7 index bits, auto-increment bit
`default_nettype none

module gysb_buffer
  import gysb_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample link
  input wire logic link_clk,
  input wire logic samp_strobe,
  input wire logic [DATA_W-1:0] samp_x,
  input wire logic [DATA_W-1:0] samp_y,
  input wire logic [DATA_W-1:0] samp_z,
  input wire logic trig_pulse,
  // pin
  output logic second_interrupt_pin
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  // ------------------------------------------------------------------
  // link crossing
  // ------------------------------------------------------------------
  gysb_samp_if sio ();

  gysb_link_sync u_link (
    .pclk(pclk),
    .link_clk(link_clk),
    .presetn(presetn),
    .samp_strobe(samp_strobe),
    .samp_x(samp_x),
    .samp_y(samp_y),
    .samp_z(samp_z),
    .trig_pulse(trig_pulse),
    .sio(sio.link)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mem_x [DEPTH];
  logic [DATA_W-1:0] mem_y [DEPTH];
  logic [DATA_W-1:0] mem_z [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [7:0] int_ctrl_q;
  logic [7:0] buf_ctrl_q;
  logic [7:0] trig_cfg_q;
  logic trig_seen_q;
  logic [5:0] rd_mask_q;
  logic [DATA_W-1:0] out_x_q;
  logic [DATA_W-1:0] out_y_q;
  logic [DATA_W-1:0] out_z_q;
  logic [6:0] burst_ptr_q;
  logic burst_on_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire logic [IDX_W-1:0] idx = paddr[IDX_LSB +: IDX_W];
  wire logic auto_inc = idx[AUTO_INC_BIT];
  wire logic addr_ok = (paddr[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (paddr[IDX_LSB-1:0] == '0);
  // a burst continues from its own pointer; a plain access ends it
  wire logic [6:0] eff = (auto_inc && burst_on_q) ? burst_ptr_q : idx[6:0];
  wire logic [6:0] eff_next = (eff == IDX_OUT_ZH) ? IDX_OUT_XL : 7'(eff + 1'b1);
  wire logic acc_cap = psel & penable & ~pready_q;
  wire logic acc_done = psel & penable & pready_q;
  wire logic is_out = (eff >= IDX_OUT_XL) && (eff <= IDX_OUT_ZH);
  wire logic [2:0] out_sel = 3'(eff - IDX_OUT_XL);
  wire logic hit_rw = (eff == IDX_INT_CTRL) || (eff == IDX_BUF_CTRL) || (eff == IDX_TRIG_CFG);
  wire logic mapped = addr_ok && (hit_rw || is_out || (eff == IDX_BUF_SRC));
  wire logic wr_int = acc_done & pwrite & mapped & (eff == IDX_INT_CTRL);
  wire logic wr_buf = acc_done & pwrite & mapped & (eff == IDX_BUF_CTRL);
  wire logic wr_trg = acc_done & pwrite & mapped & (eff == IDX_TRIG_CFG);
  wire logic rd_out = acc_done & ~pwrite & mapped & is_out;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  wire logic [2:0] mode = buf_ctrl_q[MODE_LSB +: MODE_W];
  wire logic [WTM_W-1:0] wtm = buf_ctrl_q[WTM_LSB +: WTM_W];
  wire logic m_fifo = (mode == MODE_FIFO) || ((mode == MODE_S2F) && trig_seen_q);
  wire logic m_stream = (mode == MODE_STREAM) || ((mode == MODE_B2S) && trig_seen_q) ||
                        ((mode == MODE_S2F) && !trig_seen_q);
  // unused codes fall back to bypass
  wire logic m_bypass = !m_fifo && !m_stream;
  wire logic trig_mode = (mode == MODE_B2S) || (mode == MODE_S2F);
  wire logic trig_set = sio.trig & trig_cfg_q[TRIG_EN_BIT] & trig_mode;

  // ------------------------------------------------------------------
  // buffer flow
  // ------------------------------------------------------------------
  wire logic empty = (count_q == '0);
  wire logic full = (count_q == DEPTH_C);
  wire logic wtm_hit = (count_q >= CW'(wtm));
  wire logic triplet_done = (rd_mask_q | 6'h20) == 6'h3f;
  // pop only when the triplet was read whole, ending at the z high byte
  wire logic pop = rd_out & (eff == IDX_OUT_ZH) & triplet_done & ~empty & ~m_bypass;
  // fifo behaviour takes no sample once full unless a pop frees a slot
  wire logic push = sio.valid & ~m_bypass & (~full | pop | m_stream);
  wire logic drop = push & full & ~pop;
  wire logic mem_we = sio.valid & (m_bypass | push);
  wire logic [PW-1:0] mem_wa = m_bypass ? '0 : wr_ptr_q;
  wire logic [CW-1:0] count_d = CW'(count_q + CW'(push) - CW'(pop) - CW'(drop));

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem_x[mem_wa] <= sio.x;
      mem_y[mem_wa] <= sio.y;
      mem_z[mem_wa] <= sio.z;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (m_bypass) begin
      // writing bypass is also how a filled buffer is restarted
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= push ? ptr_inc(wr_ptr_q) : wr_ptr_q;
      rd_ptr_q <= (pop | drop) ? ptr_inc(rd_ptr_q) : rd_ptr_q;
      count_q <= count_d;
    end
  end

  // ------------------------------------------------------------------
  // output triplet and control registers
  // ------------------------------------------------------------------
  // head is slot 0 in bypass (live value), oldest stored triplet otherwise
  wire logic [DATA_W-1:0] head_x = mem_x[rd_ptr_q];
  wire logic [DATA_W-1:0] head_y = mem_y[rd_ptr_q];
  wire logic [DATA_W-1:0] head_z = mem_z[rd_ptr_q];
  // frozen during a triplet read and during any apb access so bytes stay coherent
  wire logic out_load = (rd_mask_q == '0) && !psel;
  wire logic [5:0] mask_bit = rd_out ? 6'(6'h01 << out_sel) : 6'h00;
  wire logic [5:0] mask_d = (rd_out && eff == IDX_OUT_ZH) ? 6'h00 : (rd_mask_q | mask_bit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_x_q <= '0;
      out_y_q <= '0;
      out_z_q <= '0;
      rd_mask_q <= '0;
    end else begin
      rd_mask_q <= m_bypass ? 6'h00 : mask_d;
      if (out_load) begin
        out_x_q <= head_x;
        out_y_q <= head_y;
        out_z_q <= head_z;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctrl_q <= RST_INT_CTRL;
      buf_ctrl_q <= RST_BUF_CTRL;
      trig_cfg_q <= RST_TRIG_CFG;
      trig_seen_q <= 1'b0;
    end else begin
      if (wr_int) int_ctrl_q <= pwdata[7:0];
      if (wr_buf) buf_ctrl_q <= pwdata[7:0];
      if (wr_trg) trig_cfg_q <= pwdata[7:0];
      // a trigger in the same cycle as a mode write is kept
      trig_seen_q <= trig_set | (trig_seen_q & ~wr_buf);
    end
  end

  // ------------------------------------------------------------------
  // read mux and apb answer
  // ------------------------------------------------------------------
  wire logic [7:0] src_byte = {wtm_hit, full, empty, count_q[4:0]};
  wire logic [15:0] out_word = (out_sel[2:1] == 2'h0) ? out_x_q :
                               (out_sel[2:1] == 2'h1) ? out_y_q : out_z_q;
  wire logic [7:0] out_byte = out_sel[0] ? out_word[15:8] : out_word[7:0];
  wire logic [7:0] rd_byte = is_out ? out_byte :
                             (eff == IDX_INT_CTRL) ? int_ctrl_q :
                             (eff == IDX_BUF_CTRL) ? buf_ctrl_q :
                             (eff == IDX_TRIG_CFG) ? trig_cfg_q :
                             (eff == IDX_BUF_SRC) ? src_byte : 8'h00;
  wire logic [2:0] irq_src = {wtm_hit, full, empty};
  wire logic [2:0] irq_en = {int_ctrl_q[IEN_WTM_BIT], int_ctrl_q[IEN_FULL_BIT], int_ctrl_q[IEN_EMPTY_BIT]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      burst_on_q <= 1'b0;
      burst_ptr_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pready_q <= acc_cap;
      pslverr_q <= acc_cap & ~mapped;
      if (acc_cap) prdata_q <= (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      if (acc_done) begin
        burst_on_q <= auto_inc;
        burst_ptr_q <= eff_next;
      end
      irq_q <= |(irq_src & irq_en);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign second_interrupt_pin = irq_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_depth_bound: assert property (count_q <= DEPTH_C)
    else $error("fill level above depth");
  a_bypass_empty: assert property ($past(m_bypass) |-> count_q == '0 && !pop)
    else $error("bypass did not keep buffer empty");
  a_bypass_slot0: assert property (m_bypass && sio.valid |-> mem_we && mem_wa == '0)
    else $error("bypass sample not written to slot zero");
  a_fifo_stops: assert property (m_fifo && full && sio.valid && !pop
    |=> count_q == DEPTH_C && $stable(wr_ptr_q))
    else $error("full fifo mode accepted a sample");
  a_stream_drop: assert property (m_stream && full && sio.valid && !pop && !wr_buf
                                  |=> count_q == DEPTH_C && rd_ptr_q != $past(rd_ptr_q))
    else $error("full stream did not drop the oldest");
  a_wtm_irq: assert property (int_ctrl_q[IEN_WTM_BIT] && wtm_hit |=> second_interrupt_pin)
    else $error("watermark did not raise the pin");
  a_irq_quiet: assert property (int_ctrl_q[2:0] == 3'h0 |=> !second_interrupt_pin)
    else $error("pin raised with all events disabled");
  a_trig_switch: assert property (trig_set |=> trig_seen_q ##0 (mode != MODE_B2S || m_stream))
    else $error("trigger did not switch behaviour");
  a_s2f_switch: assert property (mode == MODE_S2F && trig_seen_q |-> m_fifo && !m_stream)
    else $error("stream-to-fifo not in fifo behaviour after trigger");
  a_burst_wrap: assert property (acc_done && auto_inc && eff == IDX_OUT_ZH |=> burst_ptr_q == IDX_OUT_XL)
    else $error("burst pointer did not wrap to x low byte");
  a_pop_whole: assert property (!m_bypass && $changed(rd_ptr_q) |-> $past(pop) || $past(drop))
    else $error("read pointer moved without a whole triplet");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not in one wait state");

  // pin and prdata are registered, so events show on them one cycle late
  a_empty_pin: assert property (int_ctrl_q[IEN_EMPTY_BIT] && empty
    |=> second_interrupt_pin)
    else $error("empty event did not raise the pin");
  a_full_pin: assert property (int_ctrl_q[IEN_FULL_BIT] && full
    |=> second_interrupt_pin)
    else $error("full event did not raise the pin");
  a_pin_drop: assert property ((irq_src & irq_en) == 3'h0
    |=> !second_interrupt_pin)
    else $error("pin stayed high with no enabled event");
  a_int_write: assert property (wr_int
    |=> int_ctrl_q == $past(pwdata[7:0]))
    else $error("interrupt enables not written");
  a_mode_write: assert property (wr_buf
    |=> buf_ctrl_q == $past(pwdata[7:0]))
    else $error("mode and threshold not written");
  a_src_read: assert property (acc_cap && !pwrite && mapped && eff == IDX_BUF_SRC
    |=> prdata[7:0] == $past({wtm_hit, full, empty, count_q[4:0]}))
    else $error("source flags not reported");
  a_out_frozen: assert property (rd_mask_q != 6'h00
    |=> $stable(out_x_q) && $stable(out_y_q) && $stable(out_z_q))
    else $error("output triplet changed during a read");
  a_partial_hold: assert property (rd_out && eff != IDX_OUT_ZH && !drop
    |=> $stable(rd_ptr_q))
    else $error("read pointer moved on a partial read");
  a_ro_write: assert property (acc_done && pwrite && is_out
    |=> $stable(rd_mask_q))
    else $error("write to an output register had an effect");
  a_pop_level: assert property (pop && !push
    |=> count_q == $past(count_q) - 1'b1)
    else $error("pop did not free one slot");
  a_fill_step: assert property (sio.valid && !m_bypass && !full && !pop && !wr_buf
    |=> count_q == $past(count_q) + 1'b1)
    else $error("stored sample not counted");
  a_burst_step: assert property (acc_done && auto_inc && eff != IDX_OUT_ZH
    |=> burst_ptr_q == 7'($past(eff) + 1'b1))
    else $error("burst pointer did not advance");
  a_trig_clear: assert property (wr_buf && !trig_set
    |=> !trig_seen_q)
    else $error("mode write kept an old trigger");
  a_err_ready: assert property (pslverr
    |-> pready && prdata == 32'h00000000)
    else $error("error answer malformed");

  c_stream_drop: cover property (m_stream && drop);
  c_fifo_full: cover property (m_fifo && full && sio.valid);
  c_burst_wrap: cover property (acc_done && auto_inc && eff == IDX_OUT_ZH ##[3:8] acc_done && eff == IDX_OUT_XL);
  c_trigger: cover property (trig_set && mode == MODE_S2F);
  c_bypass_write: cover property (m_bypass && mem_we);

endmodule : gysb_buffer

`default_nettype wire

// ### gysb_buffer_note_end.sv
`default_nettype none
`default_nettype wire

// ### gysb_link_src.sv
// link-side sample source standing in for the sensing chain
// assumes: link_clk runs free from the bench; calls come from tb_top
`default_nettype none

module gysb_link_src
  import gysb_pkg::*;
(
  // link clock
  input wire logic link_clk,
  // sample and trigger lines
  output logic samp_strobe,
  output logic [DATA_W-1:0] samp_x,
  output logic [DATA_W-1:0] samp_y,
  output logic [DATA_W-1:0] samp_z,
  output logic trig_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    samp_strobe = 1'b0;
    trig_pulse = 1'b0;
    samp_x = '0;
    samp_y = '0;
    samp_z = '0;
  end

  // data lines go to the inverse once the strobe drops: stale data must not look valid
  task automatic send(input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] y, input logic [DATA_W-1:0] z);
    @(posedge link_clk);
    samp_strobe <= 1'b1;
    samp_x <= x;
    samp_y <= y;
    samp_z <= z;
    @(posedge link_clk);
    samp_strobe <= 1'b0;
    samp_x <= ~x;
    samp_y <= ~y;
    samp_z <= ~z;
    // spacing leaves room for the crossing handshake
    repeat (5) @(posedge link_clk);
  endtask : send

  task automatic trig();
    @(posedge link_clk);
    trig_pulse <= 1'b1;
    @(posedge link_clk);
    trig_pulse <= 1'b0;
    repeat (5) @(posedge link_clk);
  endtask : trig

endmodule : gysb_link_src

`default_nettype wire

// ### tb_top.sv
// self-checking bench of the gyro sample buffer: apb host plus link source
// assumes: package, design and link source model compiled before this file
`default_nettype none

module tb_top
  import gysb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, link_clk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, samp_strobe, trig_pulse, irq_pin, err;
  logic [DATA_W-1:0] samp_x, samp_y, samp_z;
  logic [7:0] rd;
  logic [47:0] last_t;
  logic [47:0] q[$];
  logic [2:0] mode_m;
  int fails = 0;
  int n_compared = 0;
  int seed = 31920;

  gysb_buffer #(.DEPTH(DEPTH_DEF)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .samp_strobe(samp_strobe), .samp_x(samp_x), .samp_y(samp_y), .samp_z(samp_z),
    .trig_pulse(trig_pulse), .second_interrupt_pin(irq_pin));
  gysb_link_src src_u (.link_clk(link_clk), .samp_strobe(samp_strobe), .samp_x(samp_x), .samp_y(samp_y),
    .samp_z(samp_z), .trig_pulse(trig_pulse));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end

  // ------------------------------------------------------------------
  // compare, bus and model tasks
  // ------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic apb(input logic wr, input logic burst, input logic [6:0] idx, input logic [7:0] wd);
    int guard;
    guard = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, burst, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (guard >= 50) begin
      fails++;
      $display("[FAIL] %0t no bus answer", $time);
    end
  endtask : apb

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, 1'b0, idx, 8'h00);
    chk8(rd, exp, what);
    chk1(err, 1'b0, what);
  endtask : rd_chk

  function automatic logic [7:0] src_exp(input int n, input int thr);
    return {n >= thr, n == DEPTH_DEF, n == 0, 5'(n)};
  endfunction : src_exp

  task automatic set_mode(input logic [2:0] code, input logic [4:0] thr, input logic [2:0] m);
    apb(1'b1, 1'b0, IDX_BUF_CTRL, {code, thr});
    mode_m = m;
    if (code == MODE_BYPASS) q.delete();
  endtask : set_mode

  // model: fifo stops at depth, stream drops the oldest, bypass keeps only the last
  task automatic push(input int n);
    logic [47:0] t;
    repeat (n) begin
      t[31:0] = $random(seed);
      t[47:32] = 16'($random(seed));
      src_u.send(t[15:0], t[31:16], t[47:32]);
      last_t = t;
      if (mode_m == MODE_FIFO && q.size() < DEPTH_DEF) q.push_back(t);
      if (mode_m == MODE_STREAM) begin
        if (q.size() == DEPTH_DEF) void'(q.pop_front());
        q.push_back(t);
      end
    end
  endtask : push

  // cont: burst already running, so a decoy index must be ignored
  task automatic rd_trip(input logic [47:0] t, input logic burst, input logic cont);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, burst, (burst && (i > 0 || cont)) ? IDX_BUF_SRC : IDX_OUT_XL + 7'(i), 8'h00);
      chk8(rd, t[8*i +: 8], "output byte");
    end
  endtask : rd_trip

  task automatic pin_chk(input logic exp);
    repeat (3) @(posedge pclk);
    chk1(irq_pin, exp, "interrupt pin");
  endtask : pin_chk

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mode_m = MODE_BYPASS;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_INT_CTRL, RST_INT_CTRL, "int ctrl reset");
    rd_chk(IDX_BUF_CTRL, RST_BUF_CTRL, "buf ctrl reset");
    rd_chk(IDX_TRIG_CFG, RST_TRIG_CFG, "trig cfg reset");
    rd_chk(IDX_BUF_SRC, src_exp(0, 0), "src reset");
    apb(1'b0, 1'b0, 7'h31, 8'h00);
    chk1(err, 1'b1, "unmapped index");
    push(2);
    rd_trip(last_t, 1'b0, 1'b0);
    rd_chk(IDX_BUF_SRC, src_exp(0, 0), "bypass empty");
    apb(1'b1, 1'b0, IDX_INT_CTRL, 8'h01);
    pin_chk(1'b1);
    apb(1'b1, 1'b0, IDX_INT_CTRL, 8'h04);
    set_mode(MODE_FIFO, 5'd4, MODE_FIFO);
    push(3);
    pin_chk(1'b0);
    push(1);
    pin_chk(1'b1);
    push(30);
    rd_chk(IDX_BUF_SRC, src_exp(32, 4), "fifo full");
    rd_chk(IDX_OUT_XL, q[0][7:0], "partial read");
    rd_chk(IDX_BUF_SRC, src_exp(32, 4), "no pop on partial");
    rd_trip(q.pop_front(), 1'b1, 1'b0);
    rd_trip(q.pop_front(), 1'b1, 1'b1);
    rd_chk(IDX_BUF_SRC, src_exp(30, 4), "two pops");
    set_mode(MODE_BYPASS, 5'd0, MODE_BYPASS);
    rd_chk(IDX_BUF_SRC, src_exp(0, 0), "cleared by bypass");
    set_mode(MODE_STREAM, 5'd0, MODE_STREAM);
    push(34);
    rd_chk(IDX_BUF_SRC, src_exp(32, 0), "stream full");
    rd_trip(q.pop_front(), 1'b0, 1'b0);
    set_mode(MODE_BYPASS, 5'd0, MODE_BYPASS);
    apb(1'b1, 1'b0, IDX_TRIG_CFG, 8'h01);
    set_mode(MODE_B2S, 5'd0, MODE_BYPASS);
    push(2);
    rd_chk(IDX_BUF_SRC, src_exp(0, 0), "before trigger");
    src_u.trig();
    mode_m = MODE_STREAM;
    push(3);
    rd_chk(IDX_BUF_SRC, src_exp(3, 0), "after trigger");
    rd_trip(q.pop_front(), 1'b0, 1'b0);
    set_mode(MODE_BYPASS, 5'd0, MODE_BYPASS);
    apb(1'b1, 1'b0, IDX_INT_CTRL, 8'h02);
    set_mode(MODE_S2F, 5'd31, MODE_STREAM);
    push(33);
    src_u.trig();
    mode_m = MODE_FIFO;
    push(2);
    rd_chk(IDX_BUF_SRC, src_exp(32, 31), "s2f full");
    pin_chk(1'b1);
    rd_trip(q.pop_front(), 1'b1, 1'b0);
    set_mode(3'h7, 5'd0, MODE_BYPASS);
    push(1);
    rd_chk(IDX_BUF_SRC, src_exp(0, 0), "spare code as bypass");
    print_verdict();
  end

endmodule : tb_top

`default_nettype wire
